// ---- common/sac_pkg.sv ----
// Package for the successive-approximation converter control block.
// Assumes an 8-bit special-function register bus with byte addresses.
package sac_pkg;

    // Register addresses on the special-function bus
    localparam logic [7:0] SAC_ADDR_PRESCALE = 8'h94;
    localparam logic [7:0] SAC_ADDR_RES_LOW  = 8'h95;
    localparam logic [7:0] SAC_ADDR_RES_HIGH = 8'h96;
    localparam logic [7:0] SAC_ADDR_CTRL     = 8'h97;

    // Reset value shared by all four registers
    localparam logic [7:0] SAC_RESET_VAL     = 8'h00;

    // Control and status bit positions
    localparam int SAC_BIT_DONE   = 0;
    localparam int SAC_BIT_START  = 1;
    localparam int SAC_BIT_CH_LSB = 2;
    localparam int SAC_BIT_CH_MSB = 4;
    localparam int SAC_BIT_CONV_EN = 5;
    localparam int SAC_BIT_IRQ_EN = 6;
    localparam int SAC_BIT_IRQ_FLAG = 7;

    // Prescaler register bit positions
    localparam int SAC_BIT_DIV_LSB = 0;
    localparam int SAC_BIT_DIV_MSB = 2;
    localparam int SAC_BIT_REF_EN  = 3;

    // Conversion shape
    localparam int SAC_RES_BITS    = 10;
    localparam int SAC_STEPS_TYP   = 32;
    localparam int SAC_SAMPLE_STEPS = SAC_STEPS_TYP - SAC_RES_BITS;

    // Timing figures for documentation of the derivation
    localparam int SAC_CONV_TIME_NS = 4000;
    localparam int SAC_REF_FREQ_MHZ = 8;
    localparam int SAC_CAL_TIME_MS  = 16;

    // Register bus request carried as one bundle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sac_bus_req_t;

    // Analog front-end controls carried as one bundle
    typedef struct packed {
        logic                    power_on;
        logic                    sample;
        logic [2:0]              channel;
        logic [SAC_RES_BITS-1:0] trial;
    } sac_afe_ctrl_t;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_DECIDE
    } sac_state_t;

endpackage : sac_pkg

// ---- design/sac_ref_divider.sv ----
// Reference-clock divider: one-cycle enable pulse every div+1 cycles.
// Assumes one system clock; the divisor is held stable by software.
`timescale 1ns/10ps
module sac_ref_divider
    import sac_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // Control
    input  wire logic       enable,
    input  wire logic [2:0] div,
    // Tick out
    output logic            tick
);

    logic [2:0] cnt_r;    // Cycles counted since last tick
    logic [2:0] cnt_nxt;  // Next count
    logic       tick_nxt; // Next tick

    // Divisor 0 is treated as divide-by-one; stops when gated
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!enable) begin
            cnt_nxt = 3'h0;
        end else if (cnt_r >= div) begin
            cnt_nxt  = 3'h0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 3'h1;
        end
    end

    // Register the counter and pulse
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_r <= 3'h0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end

endmodule : sac_ref_divider

// ---- design/sac_control.sv ----
// Control logic of an eight-channel 10-bit successive-approximation converter.
// Assumes an analog front end that returns a comparator level each step.
//
// What this block and its software must do
// RQ1: Ten-bit result by successive approximation
// RQ2: Result split across low and high registers
// RQ3: Channel field bits 4..2 picks input
// RQ4: Reference clock is oscillator divided by prescaler
// RQ5: Software uses only allowed prescaler values
// RQ6: Conversion about four microseconds at 8 MHz
// RQ7: Prescaler bit 3 gates reference clock
// RQ8: Start bit begins conversion, self-clears
// RQ9: Completion loads result and sets status
// RQ10: Status low while converting, software-clearable
// RQ11: Interrupt flag set on status rising
// RQ12: Only software clears interrupt flag
// RQ13: Interrupt request needs flag and enable
// RQ14: Enable bit low powers converter off
// RQ15: Software waits calibration before starting
// RQ16: Software configures pin functions for inputs
// RQ17: All four registers reset to zero
// RQ18: Start ignored while either enable low
// RQ19: Fixed cycle count per conversion
`timescale 1ns/10ps
module sac_control
    import sac_pkg::*;
#(
    parameter int STEPS = SAC_STEPS_TYP // Reference cycles per conversion
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          srst,
    // Register bus
    input  wire sac_bus_req_t  bus_req,
    output logic [7:0]         bus_rdata,
    // Analog front end
    input  wire logic          cmp_above,
    output sac_afe_ctrl_t      afe_ctrl,
    // Processor interrupt
    output logic               irq
);

    // Comparator synchroniser, first stage feeds only the second
    logic cmp_s1_r;
    logic cmp_s2_r;

    // Register state
    logic [7:0] ctrl_r;      // Control and status
    logic [7:0] ctrl_nxt;
    logic [3:0] pres_r;      // Prescaler, bits 3..0
    logic [3:0] pres_nxt;
    logic [SAC_RES_BITS-1:0] res_r;   // Result registers
    logic [SAC_RES_BITS-1:0] res_nxt;

    // Sequencer state
    sac_state_t              state_r;
    sac_state_t              state_nxt;
    logic [5:0]              step_r;    // Steps left in sampling phase
    logic [5:0]              step_nxt;
    logic [SAC_RES_BITS-1:0] sar_r;     // Approximation register
    logic [SAC_RES_BITS-1:0] sar_nxt;
    logic [SAC_RES_BITS-1:0] probe_r;   // Bit under trial
    logic [SAC_RES_BITS-1:0] probe_nxt;

    logic ref_tick;   // One-cycle reference clock enable
    logic wr_ctrl;    // Write to control register
    logic wr_pres;    // Write to prescaler register
    logic done_set;   // Conversion finishing this cycle
    logic start_ok;   // Start accepted

    // Sampling steps taken out of the fixed total
    localparam logic [5:0] SAMPLE_CNT = 6'(STEPS - SAC_RES_BITS);

    // Address match helper
    function automatic logic hit(input sac_bus_req_t r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    assign wr_ctrl = hit(bus_req, SAC_ADDR_CTRL);
    assign wr_pres = hit(bus_req, SAC_ADDR_PRESCALE);

    // Reference clock enable from divider
    sac_ref_divider u_div (
        .mclk   (mclk),
        .srst   (srst),
        .enable (pres_r[SAC_BIT_REF_EN]),                  // RQ7
        .div    (pres_r[SAC_BIT_DIV_MSB:SAC_BIT_DIV_LSB]), // RQ4
        .tick   (ref_tick)
    );

    // Synchronise the comparator level
    always_ff @(posedge mclk) begin
        if (srst) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            cmp_s1_r <= cmp_above;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // Start is only honoured when both converter and reference clock run
    assign start_ok = ctrl_r[SAC_BIT_START] && ctrl_r[SAC_BIT_CONV_EN]
                      && pres_r[SAC_BIT_REF_EN];                 // RQ18

    // Sequencer: sample, then one decision per reference step
    always_comb begin
        state_nxt = state_r;
        step_nxt  = step_r;
        sar_nxt   = sar_r;
        probe_nxt = probe_r;
        done_set  = 1'b0;
        case (state_r)
            SAC_IDLE: begin
                if (start_ok) begin                              // RQ8
                    state_nxt = SAC_SAMPLE;
                    step_nxt  = SAMPLE_CNT;                      // RQ19
                    sar_nxt   = '0;
                    probe_nxt = {1'b1, {(SAC_RES_BITS-1){1'b0}}};
                end
            end
            SAC_SAMPLE: begin
                if (ref_tick) begin
                    if (step_r <= 6'h1) begin
                        state_nxt = SAC_DECIDE;
                    end else begin
                        step_nxt = step_r - 6'h1;
                    end
                end
            end
            SAC_DECIDE: begin
                if (ref_tick) begin
                    // Keep the trial bit when input is above trial level
                    if (cmp_s2_r) begin                          // RQ1
                        sar_nxt = sar_r | probe_r;
                    end
                    probe_nxt = probe_r >> 1;
                    if (probe_r[0]) begin
                        state_nxt = SAC_IDLE;
                        done_set  = 1'b1;                        // RQ6
                    end
                end
            end
            default: begin
                state_nxt = SAC_IDLE;
            end
        endcase
        // Power-off aborts any conversion
        if (!ctrl_r[SAC_BIT_CONV_EN]) begin                      // RQ14
            state_nxt = SAC_IDLE;
            done_set  = 1'b0;
        end
    end

    // Register next values for bus-visible state
    always_comb begin
        ctrl_nxt = ctrl_r;
        pres_nxt = pres_r;
        res_nxt  = res_r;
        // Start bit lives one cycle only
        ctrl_nxt[SAC_BIT_START] = 1'b0;                          // RQ8
        if (wr_pres) begin
            pres_nxt = bus_req.wdata[3:0];                       // RQ4
        end
        if (wr_ctrl) begin
            ctrl_nxt[SAC_BIT_IRQ_EN]  = bus_req.wdata[SAC_BIT_IRQ_EN];
            ctrl_nxt[SAC_BIT_CONV_EN] = bus_req.wdata[SAC_BIT_CONV_EN];
            ctrl_nxt[SAC_BIT_CH_MSB:SAC_BIT_CH_LSB] =
                bus_req.wdata[SAC_BIT_CH_MSB:SAC_BIT_CH_LSB];    // RQ3
            ctrl_nxt[SAC_BIT_START]   = bus_req.wdata[SAC_BIT_START];
            // Software may clear the flags, never set them
            if (!bus_req.wdata[SAC_BIT_DONE]) begin
                ctrl_nxt[SAC_BIT_DONE] = 1'b0;                   // RQ10
            end
            if (!bus_req.wdata[SAC_BIT_IRQ_FLAG]) begin
                ctrl_nxt[SAC_BIT_IRQ_FLAG] = 1'b0;               // RQ12
            end
        end
        // Status reads zero while converting
        if (start_ok) begin
            ctrl_nxt[SAC_BIT_DONE] = 1'b0;                       // RQ10
        end
        // Completion wins over a simultaneous software clear
        if (done_set) begin
            res_nxt                    = sar_nxt;                // RQ9
            ctrl_nxt[SAC_BIT_DONE]     = 1'b1;                   // RQ9
            if (!ctrl_r[SAC_BIT_DONE]) begin
                ctrl_nxt[SAC_BIT_IRQ_FLAG] = 1'b1;               // RQ11
            end
        end
    end

    // Register all state
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_r  <= SAC_RESET_VAL;                            // RQ17
            pres_r  <= SAC_RESET_VAL[3:0];                       // RQ17
            res_r   <= '0;                                       // RQ17
            state_r <= SAC_IDLE;
            step_r  <= 6'h0;
            sar_r   <= '0;
            probe_r <= '0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            pres_r  <= pres_nxt;
            res_r   <= res_nxt;
            state_r <= state_nxt;
            step_r  <= step_nxt;
            sar_r   <= sar_nxt;
            probe_r <= probe_nxt;
        end
    end

    // Read multiplexer, reserved bits read zero
    always_comb begin
        case (bus_req.addr)
            SAC_ADDR_CTRL:     bus_rdata = ctrl_r;
            SAC_ADDR_PRESCALE: bus_rdata = {4'h0, pres_r};
            SAC_ADDR_RES_LOW:  bus_rdata = res_r[7:0];             // RQ2
            SAC_ADDR_RES_HIGH: bus_rdata = {6'h00, res_r[9:8]};    // RQ2
            default:           bus_rdata = 8'h00;
        endcase
    end

    // Front-end drive
    assign afe_ctrl.power_on = ctrl_r[SAC_BIT_CONV_EN];              // RQ14
    assign afe_ctrl.sample   = (state_r == SAC_SAMPLE);
    assign afe_ctrl.channel  = ctrl_r[SAC_BIT_CH_MSB:SAC_BIT_CH_LSB]; // RQ3
    assign afe_ctrl.trial    = sar_r | probe_r;

    // Interrupt request
    assign irq = ctrl_r[SAC_BIT_IRQ_FLAG] && ctrl_r[SAC_BIT_IRQ_EN];  // RQ13

endmodule : sac_control

// ---- test/sac_control_checker.sv ----
// Port checker for the converter control block.
// Assumes it is bound to sac_control and sees only its ports.
`timescale 1ns/10ps
module sac_control_checker
    import sac_pkg::*;
#(
    parameter int STEPS = SAC_STEPS_TYP // Mirrors the design, not used here
) (
    // Clock and reset
    input wire logic          mclk,
    input wire logic          srst,
    // Register bus
    input wire sac_bus_req_t  bus_req,
    input wire logic [7:0]    bus_rdata,
    // Front end and interrupt
    input wire logic          cmp_above,
    input wire sac_afe_ctrl_t afe_ctrl,
    input wire logic          irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    wire logic ctl = (bus_req.addr == SAC_ADDR_CTRL); // Control register on the read mux

    a_irq_level: assert property (ctl |-> irq == (bus_rdata[7] & bus_rdata[6]))
        else $error("irq differs from flag and enable");
    a_afe_mirror: assert property (ctl ##1 ctl && $stable(bus_rdata[5:2]) |->
        afe_ctrl.channel == bus_rdata[4:2] && afe_ctrl.power_on == bus_rdata[5])
        else $error("front end controls differ from control register");
    a_start_clear: assert property (ctl && bus_rdata[1] ##1 ctl |-> !bus_rdata[1])
        else $error("start bit stood longer than one cycle");
    a_high_reserved: assert property (bus_req.addr == SAC_ADDR_RES_HIGH |->
        bus_rdata[7:2] == 6'h00)
        else $error("reserved result bits not zero");
    a_flag_kept: assert property (ctl && bus_rdata[7] && !bus_req.wr ##1 ctl |-> bus_rdata[7])
        else $error("interrupt flag cleared without a write");
    a_done_busy: assert property ($past(afe_ctrl.sample) && afe_ctrl.sample && ctl |->
        !bus_rdata[0])
        else $error("status set while sampling");
    a_flag_on_done: assert property (ctl && !bus_rdata[0] ##1 ctl && bus_rdata[0] |->
        bus_rdata[7])
        else $error("flag not set on completion");
    a_off_idle: assert property (!afe_ctrl.power_on [*2] |-> !afe_ctrl.sample)
        else $error("sampling while converter off");

    c_done: cover property (ctl ##1 ctl && $rose(bus_rdata[0]));
    c_irq: cover property ($rose(irq));
    c_sample: cover property ($rose(afe_ctrl.sample));
endmodule : sac_control_checker

bind sac_control sac_control_checker #(.STEPS(STEPS)) chk_u (.mclk(mclk), .srst(srst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .cmp_above(cmp_above),
    .afe_ctrl(afe_ctrl), .irq(irq));

// ---- test/sac_afe_model.sv ----
// Behavioural analog front end: input multiplexer and comparator.
// Assumes the bench hands in one ten-bit input code per channel.
`timescale 1ns/10ps
module sac_afe_model
    import sac_pkg::*;
(
    // Clock
    input wire logic          mclk,
    // Input levels and controls
    input wire logic [79:0]   levels,
    input wire sac_afe_ctrl_t afe_ctrl,
    // Comparator level
    output logic              cmp_above
);
    logic       junk_r = 1'b0; // Toggles so an unpowered comparator never looks steady
    logic [9:0] lvl;           // Level of the selected input

    // Free toggle for the powered-off case
    always_ff @(posedge mclk) junk_r <= !junk_r;

    // Input sits half a code above its value, so above and at-or-above agree
    always_comb begin
        lvl = levels[afe_ctrl.channel*10 +: 10];
        cmp_above = afe_ctrl.power_on ? ({lvl, 1'b1} > {afe_ctrl.trial, 1'b0}) : junk_r;
    end
endmodule : sac_afe_model

// ---- test/sac_control_bench.sv ----
// Self-checking bench for the converter control block.
// Assumes the behavioural front end and the bound port checker.
`timescale 1ns/10ps
module sac_control_bench
    import sac_pkg::*;
;
    logic          mclk = 1'b0;
    logic          srst = 1'b1;
    sac_bus_req_t  req  = '0;
    logic [7:0]    rdata;
    logic          cmp;
    logic          irq;
    sac_afe_ctrl_t afe;
    logic [79:0]   levels;         // Input code per channel, channel 0 lowest
    int            fail_count = 0;
    int            n_tests = 0;
    int            cycles = 0;
    int            t;
    logic [7:0]    d;
    logic [7:0]    cw;
    logic [9:0]    code;

    assign levels = {10'h3fe, 10'h001, 10'h1ff, 10'h200, 10'h155, 10'h2aa, 10'h3ff, 10'h000};

    sac_control dut_u (.mclk(mclk), .srst(srst), .bus_req(req), .bus_rdata(rdata),
        .cmp_above(cmp), .afe_ctrl(afe), .irq(irq));
    sac_afe_model afe_u (.mclk(mclk), .levels(levels), .afe_ctrl(afe), .cmp_above(cmp));

    // Clock and hang guard
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        req.rd = 1'b0;
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = v;
        @(negedge mclk);
        req.wr = 1'b0;
    endtask : wr

    // Read data is combinational on the address; taken once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge mclk);
        v = rdata;
    endtask : rd

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        srst = 1'b0;
        // Reset values, with one unmapped address
        for (int a = 8'h93; a <= 8'h97; a++) begin
            rd(8'(a), d);
            check("reset value", d, SAC_RESET_VAL);
        end
        $display("Test reset done");
        // Start without reference clock, with attempts to set both flags
        wr(SAC_ADDR_CTRL, 8'ha3);
        repeat (200) @(negedge mclk);
        rd(SAC_ADDR_CTRL, d);
        check("ignored start", d, 8'h20);
        $display("Test ignored start done");
        wr(SAC_ADDR_PRESCALE, 8'h0b);
        rd(SAC_ADDR_PRESCALE, d);
        check("prescale", d, 8'h0b);
        // One conversion per channel, interrupt enabled on odd channels
        for (int ch = 0; ch < 8; ch++) begin
            code = levels[ch*10 +: 10];
            cw = {1'b0, ch[0], 1'b1, ch[2:0], 2'b00};
            // Ones on bits 7 and 0 leave both flags alone, so only start can clear status
            wr(SAC_ADDR_CTRL, cw | 8'h81);
            // Calibration wait shortened: the block keeps no calibration timer
            repeat (20) @(negedge mclk);
            wr(SAC_ADDR_CTRL, cw | 8'h83);
            t = cycles;
            d = 8'h00;
            while (d[0] !== 1'b1 && cycles - t < 400) rd(SAC_ADDR_CTRL, d);
            check("conv time", {7'h00, (cycles - t) inside {[118:142]}}, 8'h01);
            check("status", d, cw | 8'h81);
            check("irq set", {7'h00, irq}, {7'h00, ch[0]});
            rd(SAC_ADDR_RES_LOW, d);
            check("result low", d, code[7:0]);
            rd(SAC_ADDR_RES_HIGH, d);
            check("result high", d, {6'h00, code[9:8]});
            wr(SAC_ADDR_RES_LOW, 8'h5a);
            repeat (50) @(negedge mclk);
            rd(SAC_ADDR_RES_LOW, d);
            check("result read only", d, code[7:0]);
            rd(SAC_ADDR_CTRL, d);
            check("flag held", d, cw | 8'h81);
            // Start with the converter off must leave the status flag set
            wr(SAC_ADDR_CTRL, (cw & 8'hdf) | 8'h83);
            rd(SAC_ADDR_CTRL, d);
            check("start while off", d, (cw & 8'hdf) | 8'h81);
            // Clear the interrupt flag only; status stays set for the next start
            wr(SAC_ADDR_CTRL, cw | 8'h01);
            rd(SAC_ADDR_CTRL, d);
            check("flag cleared", d, cw | 8'h01);
            check("irq cleared", {7'h00, irq}, 8'h00);
        end
        $display("Test conversions done");
        // Software clear of the status bit alone
        wr(SAC_ADDR_CTRL, 8'h7c);
        rd(SAC_ADDR_CTRL, d);
        check("status cleared", d, 8'h7c);
        // Converter switched off in mid-conversion
        wr(SAC_ADDR_CTRL, 8'h22);
        repeat (30) @(negedge mclk);
        check("sampling", {7'h00, afe.sample}, 8'h01);
        wr(SAC_ADDR_CTRL, 8'h00);
        @(negedge mclk);
        check("sampling stopped", {7'h00, afe.sample}, 8'h00);
        repeat (200) @(negedge mclk);
        rd(SAC_ADDR_CTRL, d);
        check("abort", d, 8'h00);
        check("power off", {7'h00, afe.power_on}, 8'h00);
        $display("Test abort done");
        give_verdict();
    end
endmodule : sac_control_bench
